// >>> design/dpio_pkg.sv
// constants and carrier types for the dual parallel port block
// assumes the host bus and the pins are sampled on one clock, clk
package dpio_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int SEL_W = 4;

   // ---------------------------------------------------------------
   // register numbers on the register-select inputs
   // ---------------------------------------------------------------
   localparam logic [SEL_W-1:0] REG_PORT_B = 4'h0;
   localparam logic [SEL_W-1:0] REG_PORT_A = 4'h1;
   localparam logic [SEL_W-1:0] REG_DIR_B = 4'h2;
   localparam logic [SEL_W-1:0] REG_DIR_A = 4'h3;
   localparam logic [SEL_W-1:0] REG_PORT_A_NOHS = 4'hf;

   // ---------------------------------------------------------------
   // values after reset, and the read data of unmapped registers
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_OUTPUT = 8'h00;
   localparam logic [DATA_W-1:0] RST_DIRECTION = 8'h00;
   localparam logic [DATA_W-1:0] RST_READ_DATA = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

   // ---------------------------------------------------------------
   // synchroniser depth, filter and capture bookkeeping
   // ---------------------------------------------------------------
   localparam int SYNC_STAGES = 3;
   localparam int SYNC_LATENCY_CYCLES = 4;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic chip_sel;
      logic read;
      logic [SEL_W-1:0] register_select_inputs;
      logic [DATA_W-1:0] wr_data;
   } dpio_host_req_t;

   typedef struct packed {
      logic latch_en_a;
      logic latch_en_b;
      logic rise_sel_a;
      logic rise_sel_b;
   } dpio_latch_cfg_t;

endpackage

// >>> design/dpio_sync.sv
// three-flop synchroniser with agreement filter
// assumes async_in comes from outside the clk domain
`timescale 1ns/1ns
module dpio_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] filt_out
);
   import dpio_pkg::*;

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // ---------------------------------------------------------------
   // flop chain
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // ---------------------------------------------------------------
   // change counts once stage2 and stage3 agree, per bit
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         filt_out <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (stage2[i] == stage3[i]) begin
               filt_out[i] <= stage3[i];
            end
         end
      end
   end

   a_filter_agree: assert property (@(posedge clk) disable iff (!rst_n)
      (stage2 == stage3) |=> (filt_out == $past(stage3)))
      else $error("filtered input did not follow agreeing stages");

   a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $stable(stage3) && $stable(stage2) && (stage2 != stage3) |=> $stable(filt_out))
      else $error("filtered input moved while stages disagree");

endmodule // dpio_sync

// >>> design/dpio_latch.sv
// edge-triggered input capture for one port
// assumes ctl and pins are already synchronised to clk
`timescale 1ns/1ns
module dpio_latch #(
   parameter int W = 8,
   parameter bit CLEAR_ON_READ = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ctl,
   input wire logic rise_sel,
   input wire logic enable,
   input wire logic [W-1:0] pins,
   input wire logic read_clear,
   output logic [W-1:0] captured,
   output logic held
);
   import dpio_pkg::*;

   // synchroniser output is only true once its stages have refilled
   localparam logic [2:0] SETTLE = 3'(SYNC_LATENCY_CYCLES + 1);

   logic ctl_prev;
   logic [2:0] settle;
   logic primed;
   logic active;

   // ---------------------------------------------------------------
   // edge detect, muted until the synchroniser has settled
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl_prev <= 1'b0;
      end else begin
         ctl_prev <= ctl;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         settle <= 3'h0;
      end else if (settle != SETTLE) begin
         settle <= settle + 3'h1;
      end
   end

   assign primed = (settle == SETTLE);

   assign active = primed && (rise_sel ? (ctl && !ctl_prev) : (!ctl && ctl_prev));

   // ---------------------------------------------------------------
   // capture and held flag, a new edge wins over a read
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         captured <= '0;
      end else if (enable && active) begin
         captured <= pins;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         held <= 1'b0;
      end else if (!enable) begin
         held <= 1'b0;
      end else if (active) begin
         held <= 1'b1;
      end else if (read_clear && CLEAR_ON_READ) begin
         held <= 1'b0;
      end
   end

   a_edge_capture: assert property (@(posedge clk) disable iff (!rst_n)
      enable && active |=> held && (captured == $past(pins)))
      else $error("active edge did not capture the pins");

   a_read_release: assert property (@(posedge clk) disable iff (!rst_n)
      CLEAR_ON_READ && enable && held && read_clear && !active |=> !held)
      else $error("read did not release the held value");

   a_capture_steady: assert property (@(posedge clk) disable iff (!rst_n)
      !(enable && active) |=> $stable(captured))
      else $error("captured value changed without an active edge");

endmodule // dpio_latch

// >>> design/dpio_ports.sv
// dual 8-bit parallel ports with direction and latched input registers
// assumes the host bus is synchronous to clk; pins and control inputs are not
//
// Summary of operation
// - two 8-bit ports A and B, direction chosen per line
// - port B data at register 0, port A data at register 1
// - port B direction at register 2, port A direction at 3
// - direction bit 0 makes line input undriven, 1 makes it output
// - output line drives high for output bit 1, low for 0
// - output bits of input lines are stored but leave pins undriven
// - port read returns the matching input register on the data bus
// - port A with latching off reads present pin levels
// - port A with latching on holds pins captured at active edge
// - after reading latched port A it follows pins until next edge
// - port A read returns pin level even on output lines
// - port B read returns stored output bit on output lines
// - port B input lines with latching off read present pin level
// - port B input lines with latching on read last captured level
// - latching per port enabled by auxiliary control settings
// - one control bit per port picks active edge, 0 falling, 1 rising
`timescale 1ns/1ns
module dpio_ports (
   input wire logic clk,
   input wire logic rst_n,
   input wire dpio_pkg::dpio_host_req_t host_req,
   output logic [dpio_pkg::DATA_W-1:0] host_rd_data,
   input wire dpio_pkg::dpio_latch_cfg_t auxiliary_control_reg,
   input wire logic port_a_latch_control_in,
   input wire logic port_b_latch_control_in,
   input wire logic [dpio_pkg::DATA_W-1:0] port_a_pins_in,
   output logic [dpio_pkg::DATA_W-1:0] port_a_pins_out,
   output logic [dpio_pkg::DATA_W-1:0] port_a_pins_oe_n,
   input wire logic [dpio_pkg::DATA_W-1:0] port_b_pins_in,
   output logic [dpio_pkg::DATA_W-1:0] port_b_pins_out,
   output logic [dpio_pkg::DATA_W-1:0] port_b_pins_oe_n
);
   import dpio_pkg::*;

   localparam int SYNC_W = 2 * DATA_W + 2;

   logic [DATA_W-1:0] port_a_output_reg;
   logic [DATA_W-1:0] port_b_output_reg;
   logic [DATA_W-1:0] port_a_direction_reg;
   logic [DATA_W-1:0] port_b_direction_reg;
   logic [DATA_W-1:0] port_a_input_reg;
   logic [DATA_W-1:0] port_b_input_reg;
   logic [DATA_W-1:0] next_rd_data;
   logic [DATA_W-1:0] pins_a_f;
   logic [DATA_W-1:0] pins_b_f;
   logic [DATA_W-1:0] cap_a;
   logic [DATA_W-1:0] cap_b;
   logic [DATA_W-1:0] src_b;
   logic [SYNC_W-1:0] sync_filt;
   logic ctl_a_f;
   logic ctl_b_f;
   logic held_a;
   logic held_b;
   logic wr_en;
   logic rd_en;
   logic rd_port_a;

   // ---------------------------------------------------------------
   // host access decode
   // ---------------------------------------------------------------
   assign wr_en = host_req.chip_sel && !host_req.read;
   assign rd_en = host_req.chip_sel && host_req.read;
   assign rd_port_a = rd_en && ((host_req.register_select_inputs == REG_PORT_A) ||
                                (host_req.register_select_inputs == REG_PORT_A_NOHS));

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_b_output_reg <= RST_OUTPUT;
      end else if (wr_en && host_req.register_select_inputs == REG_PORT_B) begin
         port_b_output_reg <= host_req.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_a_output_reg <= RST_OUTPUT;
      end else if (wr_en && (host_req.register_select_inputs == REG_PORT_A ||
                             host_req.register_select_inputs == REG_PORT_A_NOHS)) begin
         port_a_output_reg <= host_req.wr_data;
      end
   end

   // ---------------------------------------------------------------
   // direction registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_b_direction_reg <= RST_DIRECTION;
      end else if (wr_en && host_req.register_select_inputs == REG_DIR_B) begin
         port_b_direction_reg <= host_req.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_a_direction_reg <= RST_DIRECTION;
      end else if (wr_en && host_req.register_select_inputs == REG_DIR_A) begin
         port_a_direction_reg <= host_req.wr_data;
      end
   end

   // ---------------------------------------------------------------
   // pin drive, enable low while driving
   // ---------------------------------------------------------------
   assign port_a_pins_out = port_a_output_reg;
   assign port_b_pins_out = port_b_output_reg;
   assign port_a_pins_oe_n = ~port_a_direction_reg;
   assign port_b_pins_oe_n = ~port_b_direction_reg;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   dpio_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({port_b_latch_control_in, port_a_latch_control_in, port_b_pins_in, port_a_pins_in}),
      .filt_out(sync_filt)
   );

   assign pins_a_f = sync_filt[DATA_W-1:0];
   assign pins_b_f = sync_filt[2*DATA_W-1:DATA_W];
   assign ctl_a_f = sync_filt[2*DATA_W];
   assign ctl_b_f = sync_filt[2*DATA_W+1];

   // ---------------------------------------------------------------
   // input latching per port
   // ---------------------------------------------------------------
   dpio_latch #(
      .W(DATA_W),
      .CLEAR_ON_READ(1'b1)
   ) u_latch_a (
      .clk(clk),
      .rst_n(rst_n),
      .ctl(ctl_a_f),
      .rise_sel(auxiliary_control_reg.rise_sel_a),
      .enable(auxiliary_control_reg.latch_en_a),
      .pins(pins_a_f),
      .read_clear(rd_port_a),
      .captured(cap_a),
      .held(held_a)
   );

   dpio_latch #(
      .W(DATA_W),
      .CLEAR_ON_READ(1'b0)
   ) u_latch_b (
      .clk(clk),
      .rst_n(rst_n),
      .ctl(ctl_b_f),
      .rise_sel(auxiliary_control_reg.rise_sel_b),
      .enable(auxiliary_control_reg.latch_en_b),
      .pins(pins_b_f),
      .read_clear(1'b0),
      .captured(cap_b),
      .held(held_b)
   );

   // ---------------------------------------------------------------
   // input register views
   // ---------------------------------------------------------------
   assign port_a_input_reg = (auxiliary_control_reg.latch_en_a && held_a) ? cap_a : pins_a_f;
   assign src_b = auxiliary_control_reg.latch_en_b ? cap_b : pins_b_f;

   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_b_view
         assign port_b_input_reg[gi] = port_b_direction_reg[gi] ? port_b_output_reg[gi] : src_b[gi];
      end
   endgenerate

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb begin
      case (host_req.register_select_inputs)
         REG_PORT_B: next_rd_data = port_b_input_reg;
         REG_PORT_A: next_rd_data = port_a_input_reg;
         REG_PORT_A_NOHS: next_rd_data = port_a_input_reg;
         REG_DIR_B: next_rd_data = port_b_direction_reg;
         REG_DIR_A: next_rd_data = port_a_direction_reg;
         default: next_rd_data = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         host_rd_data <= RST_READ_DATA;
      end else if (rd_en) begin
         host_rd_data <= next_rd_data;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_reset_clears: assert property (@(posedge clk)
      !rst_n |=> (port_a_pins_oe_n == 8'hff) && (port_b_pins_oe_n == 8'hff) &&
                 (port_a_pins_out == 8'h00) && (port_b_pins_out == 8'h00))
      else $error("reset did not clear direction and output");

   a_dir_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && host_req.register_select_inputs == REG_DIR_A |=> port_a_pins_oe_n == ~$past(host_req.wr_data))
      else $error("port a direction write not reflected on enables");

   a_dir_write_b: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && host_req.register_select_inputs == REG_DIR_B |=> port_b_pins_oe_n == ~$past(host_req.wr_data))
      else $error("port b direction write not reflected on enables");

   a_out_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && host_req.register_select_inputs == REG_PORT_A |=> port_a_pins_out == $past(host_req.wr_data))
      else $error("port a output write not stored");

   a_out_write_b: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && host_req.register_select_inputs == REG_PORT_B |=>
      (port_b_pins_out == $past(host_req.wr_data)) && $stable(port_b_pins_oe_n))
      else $error("port b output write wrong or moved direction");

   a_read_a_live: assert property (@(posedge clk) disable iff (!rst_n)
      rd_port_a && !auxiliary_control_reg.latch_en_a |=> host_rd_data == $past(pins_a_f))
      else $error("unlatched port a read not pin level");

   a_read_a_held: assert property (@(posedge clk) disable iff (!rst_n)
      rd_port_a && auxiliary_control_reg.latch_en_a && held_a |=> host_rd_data == $past(cap_a))
      else $error("latched port a read not captured value");

   a_read_b_out: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && host_req.register_select_inputs == REG_PORT_B |=>
      (host_rd_data & $past(port_b_direction_reg)) == ($past(port_b_output_reg) & $past(port_b_direction_reg)))
      else $error("port b output lines did not read stored bit");

   a_read_b_in: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && host_req.register_select_inputs == REG_PORT_B && !auxiliary_control_reg.latch_en_b |=>
      (host_rd_data & ~$past(port_b_direction_reg)) == ($past(pins_b_f) & ~$past(port_b_direction_reg)))
      else $error("port b input lines did not read pin level");

   a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && host_req.register_select_inputs > REG_DIR_A && host_req.register_select_inputs < REG_PORT_A_NOHS
      |=> host_rd_data == UNMAPPED_READ)
      else $error("unmapped register read not zero");

   // ---------------------------------------------------------------
   // further checks
   // ---------------------------------------------------------------
   a_read_b_latched: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && host_req.register_select_inputs == REG_PORT_B && auxiliary_control_reg.latch_en_b |=>
      (host_rd_data & ~$past(port_b_direction_reg)) == ($past(cap_b) & ~$past(port_b_direction_reg)))
      else $error("port b latched input lines did not read capture");

   a_latch_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      !auxiliary_control_reg.latch_en_a |=> !held_a)
      else $error("port a held value kept with latching off");

   a_latch_off_b: assert property (@(posedge clk) disable iff (!rst_n)
      !auxiliary_control_reg.latch_en_b |=> !held_b)
      else $error("port b held value kept with latching off");

   a_rd_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !rd_en |=> $stable(host_rd_data))
      else $error("read data moved without a read");

   a_out_write_nohs: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && host_req.register_select_inputs == REG_PORT_A_NOHS |=> port_a_pins_out == $past(host_req.wr_data))
      else $error("port a mirror write not stored");

   a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && host_req.register_select_inputs > REG_DIR_A && host_req.register_select_inputs < REG_PORT_A_NOHS
      |=> $stable(port_a_pins_out) && $stable(port_b_pins_out) &&
          $stable(port_a_pins_oe_n) && $stable(port_b_pins_oe_n))
      else $error("unmapped register write changed port state");

   a_read_nohs: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && host_req.register_select_inputs == REG_PORT_A_NOHS && !auxiliary_control_reg.latch_en_a |=> host_rd_data == $past(pins_a_f))
      else $error("port a mirror read not pin level");

   a_read_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && host_req.register_select_inputs == REG_DIR_A |=>
      host_rd_data == ~$past(port_a_pins_oe_n))
      else $error("port a direction read wrong");

   a_read_dir_b: assert property (@(posedge clk) disable iff (!rst_n)
      rd_en && host_req.register_select_inputs == REG_DIR_B |=>
      host_rd_data == ~$past(port_b_pins_oe_n))
      else $error("port b direction read wrong");

   a_oe_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr_en && host_req.register_select_inputs == REG_DIR_A) |=>
      $stable(port_a_pins_oe_n))
      else $error("port a enables moved without direction write");

   a_oe_idle_b: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr_en && host_req.register_select_inputs == REG_DIR_B) |=>
      $stable(port_b_pins_oe_n))
      else $error("port b enables moved without direction write");

   a_out_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr_en && (host_req.register_select_inputs == REG_PORT_A ||
                  host_req.register_select_inputs == REG_PORT_A_NOHS)) |=>
      $stable(port_a_pins_out))
      else $error("port a output moved without a write");

   a_out_idle_b: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr_en && host_req.register_select_inputs == REG_PORT_B) |=>
      $stable(port_b_pins_out))
      else $error("port b output moved without a write");

endmodule // dpio_ports

// >>> verif/dpio_periph.sv
// peripheral model on the far side of both ports
// assumes the bench sets the values peripherals drive and a loading mask
`timescale 1ns/1ns
module dpio_periph (
   input wire logic [dpio_pkg::DATA_W-1:0] a_out,
   input wire logic [dpio_pkg::DATA_W-1:0] a_oe_n,
   input wire logic [dpio_pkg::DATA_W-1:0] a_val,
   input wire logic [dpio_pkg::DATA_W-1:0] b_out,
   input wire logic [dpio_pkg::DATA_W-1:0] b_oe_n,
   input wire logic [dpio_pkg::DATA_W-1:0] b_val,
   input wire logic [dpio_pkg::DATA_W-1:0] load_low,
   output logic [dpio_pkg::DATA_W-1:0] a_pins,
   output logic [dpio_pkg::DATA_W-1:0] b_pins
);
   import dpio_pkg::*;
   // ---------------------------------------------------------------
   // wire levels
   // ---------------------------------------------------------------
   // undriven lines take the peripheral value; heavy load pulls driven lines low
   assign a_pins = ((a_out & ~a_oe_n) | (a_val & a_oe_n)) & ~(load_low & ~a_oe_n);
   assign b_pins = ((b_out & ~b_oe_n) | (b_val & b_oe_n)) & ~(load_low & ~b_oe_n);
endmodule // dpio_periph

// >>> verif/dual_parallel_io_ports_bench.sv
// self-checking bench for the dual parallel port block
// assumes dpio_ports and the peripheral model dpio_periph
`timescale 1ns/1ns
module dual_parallel_io_ports_bench;
   import dpio_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   dpio_host_req_t req;
   dpio_latch_cfg_t cfg;
   logic ctl_a;
   logic ctl_b;
   logic [DATA_W-1:0] rd_data, pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n, pa_val, pb_val, load;
   int fails = 0;
   int compares = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   dpio_ports DUT (.clk(clk), .rst_n(rst_n), .host_req(req), .host_rd_data(rd_data),
      .auxiliary_control_reg(cfg), .port_a_latch_control_in(ctl_a), .port_b_latch_control_in(ctl_b),
      .port_a_pins_in(pa_in), .port_a_pins_out(pa_out), .port_a_pins_oe_n(pa_oe_n),
      .port_b_pins_in(pb_in), .port_b_pins_out(pb_out), .port_b_pins_oe_n(pb_oe_n));

   dpio_periph periph (.a_out(pa_out), .a_oe_n(pa_oe_n), .a_val(pa_val), .b_out(pb_out),
      .b_oe_n(pb_oe_n), .b_val(pb_val), .load_low(load), .a_pins(pa_in), .b_pins(pb_in));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task wr(input logic [SEL_W-1:0] sel, input logic [DATA_W-1:0] d);
      @(posedge clk);
      req <= '{chip_sel: 1'b1, read: 1'b0, register_select_inputs: sel, wr_data: d};
      @(posedge clk);
      req.chip_sel <= 1'b0;
      #1;
   endtask

   task rd(input logic [SEL_W-1:0] sel, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      req <= '{chip_sel: 1'b1, read: 1'b1, register_select_inputs: sel, wr_data: 8'h00};
      @(posedge clk);
      req.chip_sel <= 1'b0;
      #1;
      check("host_rd_data", rd_data, exp);
   endtask

   // capture, hold and release on one port with one edge polarity
   task latch_case(input logic port_b, input logic rise, input logic [DATA_W-1:0] v0, input logic [DATA_W-1:0] v1);
      logic [SEL_W-1:0] sel;
      sel = port_b ? REG_PORT_B : REG_PORT_A;
      @(posedge clk);
      cfg.latch_en_a <= ~port_b;
      cfg.latch_en_b <= port_b;
      cfg.rise_sel_a <= rise;
      cfg.rise_sel_b <= rise;
      ctl_a <= ~rise;
      ctl_b <= ~rise;
      pa_val <= v0;
      pb_val <= v0;
      cyc(8);
      ctl_a <= rise;
      ctl_b <= rise;
      cyc(8);
      pa_val <= v1;
      pb_val <= v1;
      cyc(8);
      rd(sel, v0);
      rd(sel, port_b ? v0 : v1);
      @(posedge clk);
      cfg <= '0;
      cyc(8);
      rd(sel, v1);
   endtask

   // ---------------------------------------------------------------
   // timeout
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails = fails + 1;
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      req = '0;
      cfg = '0;
      ctl_a = 1'b0;
      ctl_b = 1'b0;
      pa_val = 8'h3c;
      pb_val = 8'hff;
      load = 8'h00;
      cyc(4);
      rst_n <= 1'b1;
      #1;
      check("a_oe_n", pa_oe_n, ~RST_DIRECTION);
      check("b_oe_n", pb_oe_n, ~RST_DIRECTION);
      check("a_out", pa_out, RST_OUTPUT);
      check("b_out", pb_out, RST_OUTPUT);
      check("host_rd_data", rd_data, RST_READ_DATA);
      rd(REG_DIR_A, 8'h00);
      rd(REG_DIR_B, 8'h00);
      wr(REG_DIR_A, 8'hf0);
      wr(REG_PORT_A, 8'ha5);
      check("a_oe_n", pa_oe_n, 8'h0f);
      check("a_out", pa_out, 8'ha5);
      cyc(6);
      rd(REG_PORT_A, 8'hac);
      @(posedge clk) load <= 8'h80;
      cyc(6);
      rd(REG_PORT_A, 8'h2c);
      rd(REG_PORT_A_NOHS, 8'h2c);
      rd(REG_DIR_A, 8'hf0);
      wr(REG_DIR_A, 8'h00);
      wr(REG_PORT_A, 8'hc3);
      check("a_oe_n", pa_oe_n, 8'hff);
      wr(REG_DIR_A, 8'hff);
      check("a_oe_n", pa_oe_n, 8'h00);
      check("a_out", pa_out, 8'hc3);
      @(posedge clk) load <= 8'h00;
      cyc(6);
      rd(REG_PORT_A, 8'hc3);
      wr(REG_PORT_A_NOHS, 8'h96);
      check("a_out", pa_out, 8'h96);
      wr(REG_DIR_B, 8'h0f);
      wr(REG_PORT_B, 8'h55);
      check("b_oe_n", pb_oe_n, 8'hf0);
      check("b_out", pb_out, 8'h55);
      @(posedge clk) load <= 8'h0f;
      cyc(6);
      rd(REG_PORT_B, 8'hf5);
      rd(REG_DIR_B, 8'h0f);
      for (logic [SEL_W-1:0] s = 4'h4; s != 4'hf; s++) begin
         wr(s, 8'hff);
         rd(s, UNMAPPED_READ);
      end
      rd(REG_DIR_B, 8'h0f);
      rd(REG_DIR_A, 8'hff);
      check("a_out", pa_out, 8'h96);
      check("b_out", pb_out, 8'h55);
      wr(REG_DIR_A, 8'h00);
      wr(REG_DIR_B, 8'h00);
      @(posedge clk) load <= 8'h00;
      latch_case(1'b0, 1'b0, 8'h11, 8'h22);
      latch_case(1'b0, 1'b1, 8'h33, 8'h44);
      latch_case(1'b1, 1'b0, 8'h55, 8'h66);
      latch_case(1'b1, 1'b1, 8'h77, 8'h88);
      finish_test();
   end
endmodule // dual_parallel_io_ports_bench
